/* File: hdl/swc_regs.vh */
// register offsets, field positions, codes and timing for the sleep controller
`ifndef SWC_REGS_VH
`define SWC_REGS_VH
// ****************************************************************
// register byte addresses (printed offsets are not multiples of 4)
// ****************************************************************
`define SWC_IDX_SLEEP_CONTROL     8'h00
`define SWC_IDX_REGULATOR_CONTROL 8'h01
`define SWC_IDX_STATUS            8'h02
`define SWC_ADDR_SLEEP_CONTROL    12'h000
`define SWC_ADDR_REGULATOR_CONTROL 12'h004
`define SWC_ADDR_STATUS           12'h008
// ****************************************************************
// fields and reset values
// ****************************************************************
`define SWC_SLEEP_ARM_BIT         0
`define SWC_MODE_LSB              1
`define SWC_MODE_MSB              3
`define SWC_CUT_BIT               4
`define SWC_DRIVE_LSB             0
`define SWC_DRIVE_MSB             2
`define SWC_SLEEP_CONTROL_RST     8'h00
`define SWC_REGULATOR_CONTROL_RST 8'h00
`define SWC_MODE_IDLE             3'h0
`define SWC_MODE_STANDBY          3'h1
`define SWC_MODE_DEEP_SLEEP       3'h2
`define SWC_DRIVE_AUTO            3'h0
`define SWC_DRIVE_FULL            3'h1
`define SWC_BROWNOUT_WAIT_CODE    2'h3
// ****************************************************************
// timing
// ****************************************************************
`define SWC_BASE_WAKE_CYCLES      6
`define SWC_UNLOCK_WINDOW         4
`define SWC_CLK_MHZ               20
`define SWC_OSC_START_NS          2000
`define SWC_REG_START_NS          1000
`endif

/* File: hdl/swc_sleep_wake_controller.v */
// sleep mode selection, wake-up sequencing and regulator control
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
`include "swc_regs.vh"
module swc_sleep_wake_controller #(
   parameter OSC_START_NS = `SWC_OSC_START_NS,
   parameter REG_START_NS = `SWC_REG_START_NS
) (
   pclk,
   presetn,
   psel,
   penable,
   pwrite,
   paddr,
   pwdata,
   prdata,
   pready,
   pslverr,
   sleep_instr,
   instr_retired,
   protect_key_written,
   brownout_fuse,
   brownout_ready,
   debug_break,
   standby_run_bit,
   slow_osc_used,
   slow_osc_is_main,
   wake_any_irq,
   wake_pin_change,
   wake_two_wire_match,
   wake_config_logic,
   cpu_halt,
   main_clk_run,
   slow_osc_run,
   regulator_on,
   regulator_low_power,
   hot_leakage_active,
   sleeping
);
   input  wire        pclk;
   input  wire        presetn;
   input  wire        psel;
   input  wire        penable;
   input  wire        pwrite;
   input  wire [11:0] paddr;
   input  wire [31:0] pwdata;
   output reg  [31:0] prdata;
   output reg         pready;
   output reg         pslverr;
   input  wire        sleep_instr;
   input  wire        instr_retired;
   input  wire        protect_key_written;
   input  wire [1:0]  brownout_fuse;
   input  wire        brownout_ready;
   input  wire        debug_break;
   input  wire        standby_run_bit;
   input  wire        slow_osc_used;
   input  wire        slow_osc_is_main;
   input  wire        wake_any_irq;
   input  wire        wake_pin_change;
   input  wire        wake_two_wire_match;
   input  wire        wake_config_logic;
   output reg         cpu_halt;
   output reg         main_clk_run;
   output reg         slow_osc_run;
   output reg         regulator_on;
   output reg         regulator_low_power;
   output reg         hot_leakage_active;
   output reg         sleeping;

   // least start-up times round up to whole cycles
   localparam integer OSC_CYC = (OSC_START_NS * `SWC_CLK_MHZ + 999) / 1000;
   localparam integer REG_CYC = (REG_START_NS * `SWC_CLK_MHZ + 999) / 1000;
   localparam integer BASE_CYC = `SWC_BASE_WAKE_CYCLES;

   localparam [4:0] ST_ACTIVE = 5'h01;
   localparam [4:0] ST_IDLE   = 5'h02;
   localparam [4:0] ST_STBY   = 5'h04;
   localparam [4:0] ST_DEEP   = 5'h08;
   localparam [4:0] ST_WAKE   = 5'h10;

   // ****************************************************************
   // registers
   // ****************************************************************
   reg [7:0] sleep_control_ff;
   reg [7:0] regulator_control_ff;
   reg [4:0] state_ff;
   reg [4:0] nxt_state;
   reg       stby_clk_ff;
   reg       timer_load;
   reg [11:0] timer_value;
   wire      timer_done;
   wire      unlock_open;
   wire      acc;
   wire      wr;
   wire      prot_wr;

   wire [2:0] sleep_mode_select = sleep_control_ff[`SWC_MODE_MSB:`SWC_MODE_LSB];
   wire       sleep_arm = sleep_control_ff[`SWC_SLEEP_ARM_BIT];
   wire [2:0] regulator_drive_select =
      regulator_control_ff[`SWC_DRIVE_MSB:`SWC_DRIVE_LSB];
   wire       hot_leakage_cut = regulator_control_ff[`SWC_CUT_BIT];
   wire       mode_ok = (sleep_mode_select == `SWC_MODE_IDLE) ||
                        (sleep_mode_select == `SWC_MODE_STANDBY) ||
                        (sleep_mode_select == `SWC_MODE_DEEP_SLEEP);
   wire       want_bod = (brownout_fuse == `SWC_BROWNOUT_WAIT_CODE);

   // ****************************************************************
   // wake length
   // ****************************************************************
   // the stretch is built from what is really off during this sleep,
   // so a full-drive regulator that stayed up adds no start-up time
   // and a standby that kept its clock costs only the base cycles
   localparam [11:0] BASE_LEN = BASE_CYC[11:0];
   localparam [11:0] OSC_LEN  = OSC_CYC[11:0];
   localparam [11:0] REG_LEN  = REG_CYC[11:0];
   wire [11:0] osc_part;
   wire [11:0] reg_part;
   wire [11:0] wake_len;

   // main_clk_run and regulator_on still hold their sleep-time values
   // on the edge that sees the wake event
   assign osc_part = main_clk_run ? 12'h000 : OSC_LEN;
   assign reg_part = regulator_on ? 12'h000 : REG_LEN;
   assign wake_len = BASE_LEN + osc_part + reg_part;

   assign acc     = psel && penable;
   assign wr      = acc && pwrite;
   assign prot_wr = wr && (paddr == `SWC_ADDR_REGULATOR_CONTROL);

   swc_unlock_window #(
      .N (`SWC_UNLOCK_WINDOW)
   ) u_unlock (
      .pclk          (pclk),
      .presetn       (presetn),
      .key_written   (protect_key_written),
      .instr_retired (instr_retired),
      .used          (prot_wr),
      .open          (unlock_open)
   );

   swc_wake_timer #(
      .W (12)
   ) u_timer (
      .pclk       (pclk),
      .presetn    (presetn),
      .load       (timer_load),
      .load_value (timer_value),
      .done       (timer_done)
   );

   // ****************************************************************
   // apb slave: zero wait states, unmapped reads zero with error
   // ****************************************************************
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sleep_control_ff     <= `SWC_SLEEP_CONTROL_RST;
         regulator_control_ff <= `SWC_REGULATOR_CONTROL_RST;
         prdata               <= 32'h00000000;
         pready               <= 1'b0;
         pslverr              <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= 1'b0;
         if (psel && !penable) begin
            case (paddr)
               `SWC_ADDR_SLEEP_CONTROL:
                  prdata <= {24'h000000, 4'h0, sleep_control_ff[3:0]};
               `SWC_ADDR_REGULATOR_CONTROL:
                  prdata <= {24'h000000, 3'h0, regulator_control_ff[4],
                             1'b0, regulator_control_ff[2:0]};
               `SWC_ADDR_STATUS:
                  prdata <= {27'h0000000, state_ff};
               default: begin
                  prdata  <= 32'h00000000;
                  pslverr <= 1'b1;
               end
            endcase
         end
         if (wr && pready && paddr == `SWC_ADDR_SLEEP_CONTROL)
            sleep_control_ff <= {4'h0, pwdata[3:0]};
         // the key window closes on use, so one unlock buys one write
         if (prot_wr && pready && unlock_open)
            regulator_control_ff <= {3'h0, pwdata[4], 1'b0, pwdata[2:0]};
      end
   end

   // ****************************************************************
   // sleep state machine
   // ****************************************************************
   // no debug input other than a break alters any path below
   // deep sleep ignores every source but these three and a debug break
   wire deep_wake = wake_pin_change ||
                    (!hot_leakage_active &&
                     (wake_two_wire_match || wake_config_logic));

   always @* begin
      nxt_state   = state_ff;
      timer_load  = 1'b0;
      timer_value = 12'h000;
      case (state_ff)
         ST_ACTIVE: begin
            // reserved codes fall through: the cpu keeps running
            if (sleep_instr && sleep_arm && mode_ok) begin
               case (sleep_mode_select)
                  `SWC_MODE_IDLE:    nxt_state = ST_IDLE;
                  `SWC_MODE_STANDBY: nxt_state = ST_STBY;
                  default:           nxt_state = ST_DEEP;
               endcase
            end
         end
         ST_IDLE: begin
            if (wake_any_irq || debug_break) begin
               nxt_state   = ST_WAKE;
               timer_load  = 1'b1;
               timer_value = wake_len;
            end
         end
         ST_STBY: begin
            if (wake_any_irq || debug_break) begin
               nxt_state   = ST_WAKE;
               timer_load  = 1'b1;
               timer_value = wake_len;
            end
         end
         ST_DEEP: begin
            if (deep_wake || debug_break) begin
               nxt_state   = ST_WAKE;
               timer_load  = 1'b1;
               timer_value = wake_len;
            end
         end
         ST_WAKE: begin
            // brownout wait overlaps the count, so it only ever stretches
            if (timer_done && (!want_bod || brownout_ready))
               nxt_state = ST_ACTIVE;
         end
         default: nxt_state = ST_ACTIVE;
      endcase
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff    <= ST_ACTIVE;
         stby_clk_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         if (state_ff == ST_ACTIVE)
            stby_clk_ff <= standby_run_bit;
      end
   end

   // ****************************************************************
   // clock, regulator and cpu controls
   // ****************************************************************
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cpu_halt            <= 1'b0;
         main_clk_run        <= 1'b1;
         slow_osc_run        <= 1'b1;
         regulator_on        <= 1'b1;
         regulator_low_power <= 1'b0;
         hot_leakage_active  <= 1'b0;
         sleeping            <= 1'b0;
      end else begin
         cpu_halt <= (nxt_state != ST_ACTIVE);
         sleeping <= (nxt_state == ST_IDLE) || (nxt_state == ST_STBY) ||
                     (nxt_state == ST_DEEP);
         case (nxt_state)
            ST_IDLE: main_clk_run <= 1'b1;
            ST_STBY: main_clk_run <= stby_clk_ff;
            ST_DEEP: main_clk_run <= 1'b0;
            default: main_clk_run <= 1'b1;
         endcase
         slow_osc_run <= (nxt_state != ST_DEEP) || slow_osc_used;
         regulator_on <= !((nxt_state == ST_DEEP) ||
                           (nxt_state == ST_STBY && !stby_clk_ff)) ||
                         (regulator_drive_select == `SWC_DRIVE_FULL);
         regulator_low_power <= (regulator_drive_select == `SWC_DRIVE_AUTO) &&
                                slow_osc_is_main;
         hot_leakage_active <= (nxt_state == ST_DEEP) && hot_leakage_cut &&
            (regulator_drive_select == `SWC_DRIVE_AUTO);
      end
   end
endmodule // swc_sleep_wake_controller

/* File: hdl/swc_unlock_window.v */
// counts instructions after the protection key to open a write window
`timescale 1ns/1ps
module swc_unlock_window #(
   parameter N = 4
) (
   pclk,
   presetn,
   key_written,
   instr_retired,
   used,
   open
);
   input  wire pclk;
   input  wire presetn;
   input  wire key_written;
   input  wire instr_retired;
   input  wire used;
   output wire open;

   reg [3:0] left_ff;

   assign open = (left_ff != 4'h0);

   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         left_ff <= 4'h0;
      else if (key_written)
         left_ff <= N[3:0];
      else if (used)
         left_ff <= 4'h0;
      else if (instr_retired && open)
         left_ff <= left_ff - 4'h1;
   end
endmodule // swc_unlock_window

/* File: hdl/swc_wake_timer.v */
// down counter that measures one wake-up stretch
`timescale 1ns/1ps
module swc_wake_timer #(
   parameter W = 12
) (
   pclk,
   presetn,
   load,
   load_value,
   done
);
   input  wire         pclk;
   input  wire         presetn;
   input  wire         load;
   input  wire [W-1:0] load_value;
   output reg          done;

   reg [W-1:0] cnt_ff;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_ff <= {W{1'b0}};
         done   <= 1'b0;
      end else if (load) begin
         cnt_ff <= load_value;
         done   <= 1'b0;
      end else if (cnt_ff != {W{1'b0}}) begin
         cnt_ff <= cnt_ff - {{(W-1){1'b0}}, 1'b1};
         done   <= (cnt_ff == {{(W-1){1'b0}}, 1'b1});
      end
   end
endmodule // swc_wake_timer

/* File: testbench/swc_checker.sv */
// port checker of the sleep controller
`timescale 1ns/1ps
module swc_checker #(
   parameter OSC_START_NS = 2000,
   parameter REG_START_NS = 1000
) (
   input wire        pclk,
   input wire        presetn,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire        pready,
   input wire        sleep_instr,
   input wire [1:0]  brownout_fuse,
   input wire        brownout_ready,
   input wire        debug_break,
   input wire        wake_pin_change,
   input wire        wake_two_wire_match,
   input wire        wake_config_logic,
   input wire        cpu_halt,
   input wire        main_clk_run,
   input wire        sleeping
);
   // low bound only: full drive may skip the regulator start
   localparam int LO = 6 + OSC_START_NS / 50 - 8;
   reg  [3:0] ctl_ff;
   wire [2:0] md = ctl_ff[3:1];
   always @(posedge pclk or negedge presetn)
      if (!presetn) ctl_ff <= 4'h0;
      else if (psel && penable && pready && pwrite && paddr == 12'h000)
         ctl_ff <= pwdata[3:0];
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_armed_sleep: assert property (sleep_instr && !cpu_halt && ctl_ff[0] &&
      md < 3 |-> ##[1:3] sleeping) else $error("armed sleep missed");
   a_unarmed_run: assert property (sleep_instr && !cpu_halt && (!ctl_ff[0]
      || md > 2) |-> !sleeping[*3]) else $error("sleep not allowed");
   a_idle_clock: assert property (sleeping && $past(sleeping) && md == 0
      |-> main_clk_run) else $error("idle clock stopped");
   a_deep_clock: assert property (sleeping && $past(sleeping) && md == 2
      |-> !main_clk_run) else $error("deep clock running");
   a_idle_wake: assert property ($fell(sleeping) && md == 0 &&
      brownout_fuse != 2'h3 |-> cpu_halt[*5] ##[1:4] !cpu_halt)
      else $error("idle wake time wrong");
   a_deep_wake: assert property ($fell(sleeping) && md == 2 |-> ##LO cpu_halt)
      else $error("deep wake too short");
   a_brownout_hold: assert property (cpu_halt && !sleeping && brownout_fuse
      == 2'h3 && !brownout_ready |=> cpu_halt) else $error("ran early");
   a_debug_wake: assert property (sleeping && debug_break |-> ##[1:3]
      !sleeping) else $error("break did not wake");
   a_deep_source: assert property (sleeping && $past(sleeping) && md == 2 &&
      !debug_break && !wake_pin_change && !wake_two_wire_match &&
      !wake_config_logic |=> sleeping) else $error("bad deep wake");
   c_idle: cover property (sleeping && md == 0);
   c_deep: cover property (sleeping && md == 2);
   c_hold: cover property (cpu_halt && !sleeping && !brownout_ready);
endmodule // swc_checker
bind swc_sleep_wake_controller swc_checker #(.OSC_START_NS(OSC_START_NS),
   .REG_START_NS(REG_START_NS)) i_swc_checker (.pclk, .presetn, .psel,
   .penable, .pwrite, .paddr, .pwdata, .pready, .sleep_instr, .brownout_fuse,
   .brownout_ready, .debug_break, .wake_pin_change, .wake_two_wire_match,
   .wake_config_logic, .cpu_halt, .main_clk_run, .sleeping);

/* File: testbench/swc_cpu_model.sv */
// cpu side model: sleep instruction, retired instructions, key
`timescale 1ns/1ps
module swc_cpu_model (
   input  wire  pclk,
   output logic sleep_instr = 1'b0,
   output logic instr_retired = 1'b0,
   output logic protect_key_written = 1'b0
);
   // software arms the sleep bit before calling this
   task automatic do_sleep();
      @(posedge pclk);
      sleep_instr <= 1'b1;
      @(posedge pclk);
      sleep_instr <= 1'b0;
   endtask
   // key, then n single-cycle instruction pulses
   task automatic key_then(input int n);
      @(posedge pclk);
      protect_key_written <= 1'b1;
      @(posedge pclk);
      protect_key_written <= 1'b0;
      repeat (n) begin
         @(posedge pclk);
         instr_retired <= 1'b1;
         @(posedge pclk);
         instr_retired <= 1'b0;
      end
   endtask
endmodule // swc_cpu_model

/* File: testbench/swc_sleep_wake_controller_tb_top.sv */
// self-checking bench of the sleep controller
`timescale 1ns/1ps
module swc_sleep_wake_controller_tb_top;
   logic        pclk = 1'b0, presetn = 1'b0;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [1:0]  brownout_fuse = 2'h0;
   logic        brownout_ready = 1'b0, debug_break = 1'b0;
   logic        standby_run_bit = 1'b0, wake_any_irq = 1'b0;
   logic        wake_pin_change = 1'b0, err, pready, pslverr, sleep_instr;
   logic        instr_retired, protect_key_written, cpu_halt, main_clk_run;
   logic        hot_leakage_active, sleeping;
   logic        slow_osc_used = 1'b0, slow_osc_is_main = 1'b0;
   logic        wake_two_wire_match = 1'b0;
   logic        slow_osc_run, regulator_on, regulator_low_power;
   int          n_fail = 0, n_compared = 0, seed = 47175, win, cnt, md;
   int          mreg [2] = '{0, 0};
   always #25 pclk = ~pclk;
   swc_cpu_model i_swc_cpu_model (.pclk(pclk), .sleep_instr(sleep_instr),
      .instr_retired(instr_retired),
      .protect_key_written(protect_key_written));
   swc_sleep_wake_controller i_swc_sleep_wake_controller (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .sleep_instr(sleep_instr),
      .instr_retired(instr_retired), .brownout_ready(brownout_ready),
      .protect_key_written(protect_key_written), .debug_break(debug_break),
      .brownout_fuse(brownout_fuse), .standby_run_bit(standby_run_bit),
      .slow_osc_used(slow_osc_used), .slow_osc_is_main(slow_osc_is_main),
      .wake_any_irq(wake_any_irq), .wake_pin_change(wake_pin_change),
      .wake_two_wire_match(wake_two_wire_match),
      .wake_config_logic(1'b0),
      .cpu_halt(cpu_halt), .main_clk_run(main_clk_run),
      .slow_osc_run(slow_osc_run), .regulator_on(regulator_on),
      .regulator_low_power(regulator_low_power),
      .hot_leakage_active(hot_leakage_active), .sleeping(sleeping));
   task automatic finish_test();
      if (n_fail == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] s, e);
      n_compared++;
      if (s !== e) begin
         n_fail++;
         $display("MISMATCH %s expected %0h seen %0h", nm, e, s);
      end
   endtask
   // one apb transfer; the model takes writes only when the access ends
   task automatic apb(input logic w, input logic [11:0] a, input int d);
      int n;
      @(posedge pclk);
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
      {rd, err} = {prdata, pslverr};
      {psel, penable} <= 2'b00;
      chk("pready", pready, 1);
      if (w && a == 12'h000) mreg[0] = d & 8'h0F;
      if (w && a == 12'h004 && win) mreg[1] = d & 8'h17;
      if (w && a == 12'h004) win = 0;
   endtask
   task automatic wr_rd(input logic [11:0] a, input int d, input int keys);
      i_swc_cpu_model.key_then(keys);
      win = keys < 4;
      apb(1'b1, a, d);
      apb(1'b0, a, 0);
      chk("readback", rd, mreg[a[2]]);
   endtask
   task automatic nap(input int md, input int arm, input bit dbg);
      int base, stop, full, lowp;
      apb(1'b1, 12'h000, (md << 1) | arm);
      // inputs set just before the call have settled by now
      full = (mreg[1] & 7) == 1;
      lowp = (mreg[1] & 7) == 0 && slow_osc_is_main;
      stop = md == 2 || (md == 1 && !standby_run_bit);
      base = 6 + (stop ? 40 : 0) + ((stop && !full) ? 20 : 0);
      i_swc_cpu_model.do_sleep();
      repeat (3) @(posedge pclk);
      chk("sleeping", sleeping, arm && md < 3);
      apb(1'b0, 12'h008, 0);
      chk("status", rd, (arm && md < 3) ? 1 << (md + 1) : 1);
      if (arm && md < 3) begin
         chk("clock", main_clk_run, !stop);
         chk("slow osc", slow_osc_run, md != 2 || slow_osc_used);
         chk("regulator", regulator_on, !stop || full);
         chk("low power", regulator_low_power, lowp);
         chk("cut", hot_leakage_active, md == 2 && mreg[1] == 16);
         if (md == 2) wake_any_irq <= 1'b1;
         repeat (5) @(posedge pclk);
         chk("hold", sleeping, 1);
         if (dbg) debug_break <= 1'b1;
         else if (md == 2 && (mreg[1] & 16)) wake_pin_change <= 1'b1;
         else if (md == 2) wake_two_wire_match <= 1'b1;
         else wake_any_irq <= 1'b1;
         cnt = 0;
         do begin @(posedge pclk); cnt++; end while (cpu_halt && cnt < 300);
         {wake_any_irq, wake_pin_change, debug_break} <= 3'b000;
         wake_two_wire_match <= 1'b0;
         chk("wake", cnt >= base && cnt <= base + 3, 1);
      end
      apb(1'b0, 12'h008, 0);
      chk("active", rd, 1);
   endtask
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 12'h00C, 0);
      chk("unmapped", {rd[30:0], err}, 1);
      wr_rd(12'h004, 32'h11, 0);
      wr_rd(12'h004, 32'h11, 4);
      wr_rd(12'h004, 32'h10, 3);
      for (int i = 0; i < 12; i++) begin
         standby_run_bit <= $random(seed);
         brownout_fuse <= $random(seed);
         brownout_ready <= 1'b1;
         {slow_osc_used, slow_osc_is_main} <= $random(seed);
         nap(i % 5, i < 5 ? 1 : $random(seed) & 1, i == 1 || i == 7);
      end
      // full drive with the cut off: regulator stays up, two-wire wakes
      wr_rd(12'h004, 32'h01, 1);
      standby_run_bit <= 1'b0;
      nap(1, 1, 0);
      nap(2, 1, 0);
      {brownout_fuse, brownout_ready} <= 3'b110;
      apb(1'b1, 12'h000, 1);
      i_swc_cpu_model.do_sleep();
      repeat (3) @(posedge pclk);
      wake_any_irq <= 1'b1;
      repeat (20) @(posedge pclk);
      chk("brownout hold", cpu_halt, 1);
      brownout_ready <= 1'b1;
      repeat (4) @(posedge pclk);
      chk("brownout end", cpu_halt, 0);
      finish_test();
   end
   initial begin
      #2000000;
      n_fail++;
      finish_test();
   end
endmodule // swc_sleep_wake_controller_tb_top
